/* inc/retimer_cfg.svh */
`ifndef RETIMER_CFG_SVH
`define RETIMER_CFG_SVH

// Channel count and register widths
`define NUM_CH          2
`define REG_W           8
`define MV_W            11
`define LVL_W           2

// Register offsets
`define OFS_CH_CTRL     8'h00
`define OFS_DEEMPH      8'h15
`define OFS_SWING       8'h2d
`define OFS_EQ_BOOST    8'h3a
`define OFS_CH_SELECT   8'hff

// Field positions
`define CH_RST_BIT      2
`define CODE_HI         2
`define CODE_LO         0
`define DEEMPH_RNG_BIT  6
`define SEL_SHARED_BIT  2
`define SEL_CH_BIT      0

// Reset values
`define DEEMPH_RST      8'h00
`define SWING_RST       8'h00
`define EQ_BOOST_RST    8'h00
`define CH_SELECT_RST   8'h00
`define CH_RST_RST      1'b0
`define RDATA_RST       8'h00

// Swing amplitude: base plus step times code, in mVppd
`define SWING_BASE_MV   11'h258
`define SWING_STEP_MV   11'h064

// Pin-mode subset codes for the four pin levels
`define PIN_SWING_LO    3'h0
`define PIN_SWING_R     3'h1
`define PIN_SWING_F     3'h4
`define PIN_SWING_HI    3'h5
`define PIN_DEEMPH_LO   3'h0
`define PIN_DEEMPH_R    3'h1
`define PIN_DEEMPH_F    3'h2
`define PIN_DEEMPH_HI   3'h4

`endif

/* inc/retimer_pkg.sv */
package retimer_pkg;

    // Level seen on a four-level strap pin
    typedef enum logic [1:0] {
        LVL_LOW   = 2'h0,
        LVL_R     = 2'h1,
        LVL_F     = 2'h2,
        LVL_HIGH  = 2'h3
    } pin_lvl_e;

    // Rate range the CDR has locked in
    typedef enum logic [1:0] {
        RATE_FULL  = 2'h0,
        RATE_DIV2  = 2'h1,
        RATE_DIV4  = 2'h2,
        RATE_DIV8  = 2'h3
    } rate_range_e;

    // One register access from the management bus slave
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Decoded driver settings for one channel
    typedef struct packed {
        logic [2:0]  swing_code;
        logic [10:0] swing_mv;
        logic [7:0]  deemph_tenth_db;
        logic [7:0]  eq_boost;
        logic        fixed_eq;
    } drv_cfg_s;

endpackage

/* logic/level_sync.sv */
`timescale 1ns/1ps
`include "retimer_cfg.svh"

// Two-stage synchroniser, one pair of flops per bit
module level_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_r;   // First stage, read only by the second

    genvar b;
    generate
        for (b = 0; b < W; b++) begin : g_bit
            // Second flop alone looks at the first
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    meta_r[b]   <= 1'b0;
                    sync_out[b] <= 1'b0;
                end else begin
                    meta_r[b]   <= async_in[b];
                    sync_out[b] <= meta_r[b];
                end
            end
        end
    endgenerate

endmodule

/* logic/retimer_driver_config_regs.sv */
`timescale 1ns/1ps
`include "retimer_cfg.svh"

// Overview of operation
// - Swing code from bits 2:0 at output_swing_ctrl
// - Swing amplitude is 600 plus 100n mVppd
// - Pin mode reaches only four swing levels
// - De-emphasis from driver_deemphasis_ctrl code and range bit
// - Range clear: 0.0 down to -12.0 dB
// - Range set: 0.0 down to -5.6 dB
// - Low rate ranges use low_rate_eq_boost boost, no adaptation
// - Each channel owns its own register copy
// - Register channel_target_select steers accesses to a target
// - Target holds until channel_target_select is rewritten
// - One channel_target_select register, reachable from any target
// - Bit 2 of 0x00 resets channel, self-clears
module retimer_driver_config_regs (
    // Clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rstn,
    // Register access from the management bus slave
    input  wire retimer_pkg::reg_req_s    req,
    output logic [`REG_W-1:0]             rdata_r,
    output logic                          rvalid_r,
    // Strap pins, asynchronous
    input  wire logic                     serial_mgmt_enable_pin,
    input  wire logic [`NUM_CH-1:0][1:0]  swing_select_pins,
    input  wire logic [`NUM_CH-1:0][1:0]  deemph_select_pins,
    // Locked rate range per channel, from the CDR
    input  wire logic [`NUM_CH-1:0][1:0]  rate_range,
    // Decoded driver settings and target selection
    output retimer_pkg::drv_cfg_s [`NUM_CH-1:0] drv_cfg_r,
    output logic [`REG_W-1:0]             ch_select_r
);

    localparam int PW = 1 + 4 * `NUM_CH;   // Synchronised pin bits

    logic [PW-1:0]               pins_s;     // Pins after two flops
    logic                        smb_en;     // Register mode enabled
    logic [`REG_W-1:0]           ch_select_nxt;
    logic [`REG_W-1:0]           rdata_nxt;
    logic                        rvalid_nxt;
    logic                        tgt_shared; // Shared set selected
    logic [`NUM_CH-1:0]          tgt_hit;    // Channel selected

    // Per-channel register copies
    logic [`NUM_CH-1:0][`REG_W-1:0] deemph_r, deemph_nxt;
    logic [`NUM_CH-1:0][`REG_W-1:0] swing_r, swing_nxt;
    logic [`NUM_CH-1:0][`REG_W-1:0] eq_r, eq_nxt;
    logic [`NUM_CH-1:0]             ch_rst_r, ch_rst_nxt;
    retimer_pkg::drv_cfg_s [`NUM_CH-1:0] drv_cfg_nxt;

    // Pins cross into the clock domain before anything decodes them
    level_sync #(
        .W        (PW)
    ) u_pin_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in ({serial_mgmt_enable_pin, swing_select_pins,
                    deemph_select_pins}),
        .sync_out (pins_s)
    );

    assign smb_en = pins_s[PW-1];

    // Pin level to swing code; only four of eight levels exist here
    function automatic logic [2:0] pin_swing(input logic [1:0] lvl);
        logic [2:0] c;
        c = `PIN_SWING_LO;
        unique case (retimer_pkg::pin_lvl_e'(lvl))
            retimer_pkg::LVL_LOW:  c = `PIN_SWING_LO;
            retimer_pkg::LVL_R:    c = `PIN_SWING_R;
            retimer_pkg::LVL_F:    c = `PIN_SWING_F;
            retimer_pkg::LVL_HIGH: c = `PIN_SWING_HI;
        endcase
        return c;
    endfunction

    // Pin level to de-emphasis code, always with range clear
    function automatic logic [2:0] pin_deemph(input logic [1:0] lvl);
        logic [2:0] c;
        c = `PIN_DEEMPH_LO;
        unique case (retimer_pkg::pin_lvl_e'(lvl))
            retimer_pkg::LVL_LOW:  c = `PIN_DEEMPH_LO;
            retimer_pkg::LVL_R:    c = `PIN_DEEMPH_R;
            retimer_pkg::LVL_F:    c = `PIN_DEEMPH_F;
            retimer_pkg::LVL_HIGH: c = `PIN_DEEMPH_HI;
        endcase
        return c;
    endfunction

    // De-emphasis in tenths of a dB of attenuation
    function automatic logic [7:0] deemph_att(input logic [2:0] code,
                                              input logic       rng);
        logic [7:0] t;
        t = 8'h00;
        if (rng) begin
            unique case (code)
                3'h0: t = 8'h00;
                3'h1: t = 8'h09;
                3'h2: t = 8'h14;
                3'h3: t = 8'h1c;
                3'h4: t = 8'h21;
                3'h5: t = 8'h27;
                3'h6: t = 8'h2d;
                3'h7: t = 8'h38;
            endcase
        end else begin
            unique case (code)
                3'h0: t = 8'h00;
                3'h1: t = 8'h0f;
                3'h2: t = 8'h23;
                3'h3: t = 8'h32;
                3'h4: t = 8'h3c;
                3'h5: t = 8'h4b;
                3'h6: t = 8'h5a;
                3'h7: t = 8'h78;
            endcase
        end
        return t;
    endfunction

    // Target decode; channel_target_select sits outside it so it is never hidden
    always_comb begin
        tgt_shared = ch_select_r[`SEL_SHARED_BIT];
        for (int i = 0; i < `NUM_CH; i++) begin
            tgt_hit[i] = !tgt_shared &&
                         (ch_select_r[`SEL_CH_BIT] == 1'(i));
        end
    end

    // Channel select keeps its value until written again
    always_comb begin
        ch_select_nxt = ch_select_r;
        if (req.wr && req.addr == `OFS_CH_SELECT) begin
            ch_select_nxt = req.wdata;
        end
    end

    // Per-channel register next values
    always_comb begin
        for (int i = 0; i < `NUM_CH; i++) begin
            deemph_nxt[i] = deemph_r[i];
            swing_nxt[i]  = swing_r[i];
            eq_nxt[i]     = eq_r[i];
            ch_rst_nxt[i] = 1'b0;           // Self-clears after one cycle
            if (ch_rst_r[i]) begin
                // Defaults reloaded; a write in the same cycle still lands
                deemph_nxt[i] = `DEEMPH_RST;
                swing_nxt[i]  = `SWING_RST;
                eq_nxt[i]     = `EQ_BOOST_RST;
            end
            if (req.wr && tgt_hit[i]) begin
                unique case (req.addr)
                    `OFS_CH_CTRL:
                        ch_rst_nxt[i] = req.wdata[`CH_RST_BIT];
                    `OFS_DEEMPH:   deemph_nxt[i] = req.wdata;
                    `OFS_SWING:    swing_nxt[i]  = req.wdata;
                    `OFS_EQ_BOOST: eq_nxt[i]     = req.wdata;
                    default: ;  // Unmodelled offsets ignore writes
                endcase
            end
        end
    end

    // Read mux; one cycle from strobe to data
    always_comb begin
        rvalid_nxt = req.rd;
        rdata_nxt  = rdata_r;       // Data holds between reads
        if (req.rd) begin
            rdata_nxt = `RDATA_RST; // Unmapped and shared offsets read 0
            if (req.addr == `OFS_CH_SELECT) begin
                rdata_nxt = ch_select_r;
            end else begin
                for (int i = 0; i < `NUM_CH; i++) begin
                    if (tgt_hit[i]) begin
                        unique case (req.addr)
                            `OFS_CH_CTRL:
                                rdata_nxt[`CH_RST_BIT] = ch_rst_r[i];
                            `OFS_DEEMPH:   rdata_nxt = deemph_r[i];
                            `OFS_SWING:    rdata_nxt = swing_r[i];
                            `OFS_EQ_BOOST: rdata_nxt = eq_r[i];
                            default: ;
                        endcase
                    end
                end
            end
        end
    end

    // Driver setting decode; pins win when register mode is off
    always_comb begin
        for (int i = 0; i < `NUM_CH; i++) begin
            logic [2:0] sc;
            logic [2:0] dc;
            logic       dr;
            sc = swing_r[i][`CODE_HI:`CODE_LO];
            dc = deemph_r[i][`CODE_HI:`CODE_LO];
            dr = deemph_r[i][`DEEMPH_RNG_BIT];
            if (!smb_en) begin
                // Swing pins sit above the de-emphasis pins, channel 0 lowest
                sc = pin_swing(pins_s[`LVL_W*(`NUM_CH+i) +: `LVL_W]);
                dc = pin_deemph(pins_s[`LVL_W*i +: `LVL_W]);
                dr = 1'b0;
            end
            drv_cfg_nxt[i].swing_code = sc;
            drv_cfg_nxt[i].swing_mv   = `SWING_BASE_MV +
                                        `SWING_STEP_MV * {8'h00, sc};
            drv_cfg_nxt[i].deemph_tenth_db = deemph_att(dc, dr);
            drv_cfg_nxt[i].eq_boost   = eq_r[i];
            // Low rate ranges take the fixed boost, adaptation held off
            drv_cfg_nxt[i].fixed_eq   =
                (rate_range[i] == retimer_pkg::RATE_DIV4) ||
                (rate_range[i] == retimer_pkg::RATE_DIV8);
        end
    end

    // State registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ch_select_r <= `CH_SELECT_RST;
            rdata_r     <= `RDATA_RST;
            rvalid_r    <= 1'b0;
            for (int i = 0; i < `NUM_CH; i++) begin
                deemph_r[i]  <= `DEEMPH_RST;
                swing_r[i]   <= `SWING_RST;
                eq_r[i]      <= `EQ_BOOST_RST;
                ch_rst_r[i]  <= `CH_RST_RST;
                drv_cfg_r[i] <= '0;
            end
        end else begin
            ch_select_r <= ch_select_nxt;
            rdata_r     <= rdata_nxt;
            rvalid_r    <= rvalid_nxt;
            deemph_r    <= deemph_nxt;
            swing_r     <= swing_nxt;
            eq_r        <= eq_nxt;
            ch_rst_r    <= ch_rst_nxt;
            drv_cfg_r   <= drv_cfg_nxt;
        end
    end

endmodule

/* sim/retimer_cfg_properties.sv */
`timescale 1ns/1ps
`include "retimer_cfg.svh"

// Port-level watch on the register block
module retimer_cfg_checker (
    // Clock and reset
    input wire logic                        core_clk,
    input wire logic                        rstn,
    // Management access
    input wire retimer_pkg::reg_req_s       req,
    input wire logic [7:0]                  rdata_r,
    input wire logic                        rvalid_r,
    // Pins and decoded outputs
    input wire logic                        serial_mgmt_enable_pin,
    input wire logic [1:0][1:0]             rate_range,
    input wire retimer_pkg::drv_cfg_s [1:0] drv_cfg_r,
    input wire logic [7:0]                  ch_select_r
);
    logic [2:0] pin_lo_r;   // Cycles with pins in charge, saturating
    logic [2:0] pin_lo_nxt; // Next count

    // Count long enough to cover the synchroniser and the decode stage
    always_comb begin
        pin_lo_nxt = pin_lo_r + 3'(pin_lo_r != 3'h7);
        if (serial_mgmt_enable_pin) begin
            pin_lo_nxt = 3'h0;
        end
    end

    // Register the count
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_lo_r <= 3'h0;
        end else begin
            pin_lo_r <= pin_lo_nxt;
        end
    end

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    rd_answer_a: assert property (
        $past(rstn) |-> rvalid_r == $past(req.rd))
        else $error("read answer strobe wrong");
    sel_write_a: assert property (
        req.wr && req.addr == 8'hff |=> ch_select_r == $past(req.wdata))
        else $error("target select not written");
    sel_hold_a: assert property (
        !(req.wr && req.addr == 8'hff) |=> $stable(ch_select_r))
        else $error("target select changed by itself");
    sel_read_a: assert property (
        req.rd && req.addr == 8'hff |=> rdata_r == $past(ch_select_r))
        else $error("target select read back wrong");
    shared_read_a: assert property (
        req.rd && req.addr != 8'hff && ch_select_r[2] |=> rdata_r == 8'h00)
        else $error("shared target read not zero");
    swing_mv_a: assert property (
        $past(rstn) |->
        drv_cfg_r[0].swing_mv ==
            11'h258 + 11'h064 * drv_cfg_r[0].swing_code
        && drv_cfg_r[1].swing_mv ==
            11'h258 + 11'h064 * drv_cfg_r[1].swing_code)
        else $error("swing amplitude does not match code");
    fixed_eq_a: assert property (
        $past(rstn, 3) && rate_range == $past(rate_range)
        && rate_range == $past(rate_range, 2) |->
        drv_cfg_r[0].fixed_eq == rate_range[0][1]
        && drv_cfg_r[1].fixed_eq == rate_range[1][1])
        else $error("fixed equaliser flag wrong for rate");
    pin_swing_a: assert property (
        pin_lo_r == 3'h7 |->
        !drv_cfg_r[0].swing_code[1] && !drv_cfg_r[1].swing_code[1])
        else $error("pin mode reached a register-only swing");
endmodule

bind retimer_driver_config_regs retimer_cfg_checker u_chk (
    .core_clk(core_clk), .rstn(rstn), .req(req), .rdata_r(rdata_r),
    .rvalid_r(rvalid_r), .serial_mgmt_enable_pin(serial_mgmt_enable_pin),
    .rate_range(rate_range), .drv_cfg_r(drv_cfg_r),
    .ch_select_r(ch_select_r));

/* sim/mgmt_host.sv */
`timescale 1ns/1ps

// Management host: one strobed access at a time
module mgmt_host (
    // Clock
    input wire logic             core_clk,
    // Request out, answer in
    output retimer_pkg::reg_req_s req,
    input wire logic [7:0]       rdata_r,
    input wire logic             rvalid_r
);
    initial req = '0;

    // One-cycle strobe; address and data scrambled once released
    task automatic xfer(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q, output logic v);
        @(posedge core_clk);
        #1;
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge core_clk);
        #1;
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        q = rdata_r;
        v = rvalid_r;
    endtask
endmodule

/* sim/tb.sv */
`timescale 1ns/1ps
`include "retimer_cfg.svh"

module tb;
    logic                        core_clk;
    logic                        rstn;
    retimer_pkg::reg_req_s       req;
    logic [7:0]                  rdata_r;
    logic                        rvalid_r;
    logic                        serial_mgmt_enable_pin;
    logic [1:0][1:0]             swing_select_pins;
    logic [1:0][1:0]             deemph_select_pins;
    logic [1:0][1:0]             rate_range;
    retimer_pkg::drv_cfg_s [1:0] drv_cfg_r;
    logic [7:0]                  ch_select_r;
    int n_fail;
    int total_checks;
    int sw [2], de [2], eq [2], sel; // Reference register copies
    int dtab [16] = '{0,15,35,50,60,75,90,120,0,9,20,28,33,39,45,56};
    int stab [4] = '{0,1,4,5};       // Pin swing subset
    int ptab [4] = '{0,15,35,60};    // Pin de-emphasis subset

    retimer_driver_config_regs u_dut (.core_clk(core_clk), .rstn(rstn),
        .req(req), .rdata_r(rdata_r), .rvalid_r(rvalid_r),
        .serial_mgmt_enable_pin(serial_mgmt_enable_pin),
        .swing_select_pins(swing_select_pins),
        .deemph_select_pins(deemph_select_pins), .rate_range(rate_range),
        .drv_cfg_r(drv_cfg_r), .ch_select_r(ch_select_r));
    mgmt_host u_host (.core_clk(core_clk), .req(req), .rdata_r(rdata_r),
        .rvalid_r(rvalid_r));

    task automatic chk(input logic [15:0] got, input int exp);
        total_checks++;
        if (got !== 16'(exp)) begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, got, 16'(exp));
        end
    endtask

    // Write, then mirror it in the reference copy
    task automatic w(input logic [7:0] a, d);
        logic [7:0] q;
        logic v;
        u_host.xfer(1'b1, a, d, q, v);
        if (a == 8'hff) sel = d;
        else if (!sel[2] && a == 8'h2d) sw[sel[0]] = d;
        else if (!sel[2] && a == 8'h15) de[sel[0]] = d;
        else if (!sel[2] && a == 8'h3a) eq[sel[0]] = d;
        else if (!sel[2] && a == 8'h00 && d[2]) begin
            {sw[sel[0]], de[sel[0]], eq[sel[0]]} = '0;
        end
    endtask

    // Read; unmapped places and the shared target read zero
    task automatic r(input logic [7:0] a);
        logic [7:0] q;
        logic v;
        int e;
        u_host.xfer(1'b0, a, 8'h00, q, v);
        e = 0;
        if (a == 8'hff) e = sel;
        else if (!sel[2] && a == 8'h2d) e = sw[sel[0]];
        else if (!sel[2] && a == 8'h15) e = de[sel[0]];
        else if (!sel[2] && a == 8'h3a) e = eq[sel[0]];
        chk(16'(v), 1);
        chk(q, e);
    endtask

    // Let a write reach the decoded outputs, then compare both channels
    task automatic dchk();
        repeat (2) @(posedge core_clk);
        #1;
        for (int c = 0; c < 2; c++) begin
            chk(drv_cfg_r[c].swing_code, sw[c] & 7);
            chk(drv_cfg_r[c].swing_mv, 600 + 100 * (sw[c] & 7));
            chk(drv_cfg_r[c].deemph_tenth_db,
                dtab[{de[c][6], de[c][2:0]}]);
            chk(drv_cfg_r[c].fixed_eq, rate_range[c][1]);
            if (rate_range[c][1]) chk(drv_cfg_r[c].eq_boost, eq[c]);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Whole run needs a few hundred cycles
    initial begin
        #(25 * 20000);
        $display("[FAIL] %0t watchdog expired", $time);
        n_fail++;
        report_and_stop();
    end

    initial begin
        void'($urandom(13051));
        rstn = 1'b0;
        serial_mgmt_enable_pin = 1'b1;
        swing_select_pins = '0;
        deemph_select_pins = '0;
        rate_range = '0;
        repeat (6) @(posedge core_clk);
        #1 rstn = 1'b1;
        r(8'hff);
        r(8'h2d);
        $display("reset values done");
        for (int c = 0; c < 2; c++) begin
            w(8'hff, 8'(c));
            for (int k = 0; k < 8; k++) begin
                w(8'h2d, 8'(($urandom & 8'hf8) | k));
                r(8'h2d);
                dchk();
            end
        end
        $display("swing done");
        for (int k = 0; k < 16; k++) begin
            w(8'hff, 8'(k & 1));
            w(8'h15, 8'(($urandom & 8'hb8) | ((k & 8) << 3) | (k & 7)));
            dchk();
        end
        $display("de-emphasis done");
        for (int k = 0; k < 4; k++) begin
            rate_range = {2'(k), 2'(3 - k)};
            w(8'h3a, 8'($urandom));
            dchk();
        end
        $display("low rate boost done");
        w(8'hff, 8'h04);
        w(8'h2d, 8'h07);
        r(8'h2d);
        r(8'hff);
        w(8'hff, 8'h00);
        w(8'h40, 8'h5a);
        r(8'h40);
        w(8'h00, 8'h04);
        r(8'h00);
        r(8'h15);
        w(8'hff, 8'h01);
        r(8'h2d);
        dchk();
        $display("target and channel reset done");
        serial_mgmt_enable_pin = 1'b0;
        for (int k = 0; k < 4; k++) begin
            swing_select_pins = {2'(k), 2'(3 - k)};
            deemph_select_pins = {2'(3 - k), 2'(k)};
            repeat (6) @(posedge core_clk);
            #1;
            for (int c = 0; c < 2; c++) begin
                chk(drv_cfg_r[c].swing_code,
                    stab[swing_select_pins[c]]);
                chk(drv_cfg_r[c].deemph_tenth_db,
                    ptab[deemph_select_pins[c]]);
            end
        end
        serial_mgmt_enable_pin = 1'b1;
        repeat (4) @(posedge core_clk);
        dchk();
        $display("pin mode done");
        report_and_stop();
    end
endmodule
